// >>> hw/dcc_pkg.sv
/*
 * package for the debug comms channel: register offsets, field positions,
 * reset values and carrier structs.
 * assumes a 32-bit axi4-lite register bus and one core clock.
 */
package dcc_pkg;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] ADDR_STATUS_EXT = 8'h00;
	localparam logic [7:0] ADDR_RX_EXT     = 8'h04;
	localparam logic [7:0] ADDR_TX_EXT     = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_CLR    = 8'h10;
	localparam logic [7:0] ADDR_IRQ_EN     = 8'h14;
	localparam logic [7:0] ADDR_CORE_RX    = 8'h18;
	localparam logic [7:0] ADDR_CORE_TX    = 8'h1C;

	// ****************************************************************
	// status view field positions
	// ****************************************************************
	localparam int POS_RX_FULL      = 0;
	localparam int POS_TX_FULL      = 1;
	localparam int POS_RX_LATCHED   = 2;
	localparam int POS_TX_LATCHED   = 3;
	localparam int POS_ABORT_STICKY = 4;
	localparam int POS_ABORT_DISC   = 5;
	localparam int POS_HALTED       = 6;
	localparam int POS_DBG_ACK      = 7;
	localparam int POS_MODE_LO      = 8;

	// ****************************************************************
	// mode encodings and reset values
	// ****************************************************************
	localparam logic [1:0] MODE_NONBLOCK = 2'h0;
	localparam logic [1:0] MODE_RESET    = MODE_NONBLOCK;
	localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
	localparam int IRQ_W = 4;
	localparam int IRQ_RX_DROP  = 0;
	localparam int IRQ_ABORT    = 1;
	localparam int IRQ_RX_READY = 2;
	localparam int IRQ_TX_READY = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	localparam int HALT_DRAIN_CYCLES = 2;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} dcc_req_s;

	typedef struct packed {
		logic        hit;
		logic [31:0] rdata;
	} dcc_rsp_s;

	typedef struct packed {
		logic        req;
		logic        in_halt;
		logic        dbg_ack;
		logic        abort_in;
	} dcc_core_s;

endpackage

// >>> hw/dcc_sync.sv
/*
 * two-flop synchroniser for one level.
 * assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dcc_sync (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic d,
	output logic      q
);
	logic meta_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= 1'b0;
			q       <= 1'b0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// >>> hw/dcc_axil.sv
/*
 * axi4-lite slave front end: accepts aw and w in either order, one write
 * and one read at a time, hands a one-cycle request to the register file.
 * assumes the register file answers combinationally in the request cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module dcc_axil (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [7:0]        s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	input  wire logic [7:0]        s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	output dcc_pkg::dcc_req_s      req,
	input  wire dcc_pkg::dcc_rsp_s rsp
);
	typedef struct packed {
		logic        aw_have;
		logic        w_have;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} dcc_axil_s;

	dcc_axil_s st_ff;
	dcc_axil_s nxt_st;
	logic      do_wr;
	logic      do_rd;

	assign s_awready = !st_ff.aw_have && !st_ff.bvalid;
	assign s_wready  = !st_ff.w_have && !st_ff.bvalid;
	assign s_arready = !st_ff.rvalid && !do_wr;
	assign s_bvalid  = st_ff.bvalid;
	assign s_bresp   = st_ff.bresp;
	assign s_rvalid  = st_ff.rvalid;
	assign s_rresp   = st_ff.rresp;
	assign s_rdata   = st_ff.rdata;
	// write wins over a read in the same cycle; strobes are whole-word
	assign do_wr = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
	assign do_rd = s_arvalid && s_arready;

	always_comb begin
		req.wr    = do_wr && (s_wstrb != 4'h0 || 1'b1);
		req.rd    = do_rd;
		req.addr  = do_wr ? st_ff.awaddr : s_araddr;
		req.wdata = st_ff.wdata;
	end

	always_comb begin
		nxt_st = st_ff;
		if (s_awvalid && s_awready) begin
			nxt_st.aw_have = 1'b1;
			nxt_st.awaddr  = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			nxt_st.w_have = 1'b1;
			nxt_st.wdata  = s_wdata;
		end
		if (do_wr) begin
			nxt_st.aw_have = 1'b0;
			nxt_st.w_have  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			nxt_st.bresp   = rsp.hit ? dcc_pkg::AXI_OKAY : dcc_pkg::AXI_SLVERR;
		end
		if (st_ff.bvalid && s_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (do_rd) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = rsp.rdata;
			nxt_st.rresp  = rsp.hit ? dcc_pkg::AXI_OKAY : dcc_pkg::AXI_SLVERR;
		end
		if (st_ff.rvalid && s_rready) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

// >>> hw/dcc_top.sv
/*
 * debug comms channel: receive and transmit transfer registers between an
 * external debugger (axi4-lite) and the processor core, latched full flags
 * for non-blocking flow control, and asynchronous-abort discard handling.
 * assumes core-side strobes are on clk; abort and halt pins are async.
 */
// Operation
// - non-blocking mode when mode field is 00
// - core rx read clears full, latched stays
// - debugger rx writes ignored while latched set, non-blocking mode only
// - status read copies rx full to latched
// - debugger rx write updates latched rx flag
// - latched tx updated on status, tx read
// - tx full while undrained; rx zero empty
// - discard set: drop abort, set sticky and abort irq
// - drain outstanding aborts before halt entry
// - discard bit set on halt entry
// - outside halt never discard, even with ack
// - mode field resets to non-blocking
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	input  wire logic        core_rx_rd,
	input  wire logic        core_tx_wr,
	input  wire logic [31:0] core_tx_data,
	output logic [31:0]      core_rx_data,
	output logic             core_rx_full,
	output logic             core_tx_full,
	input  wire logic        halt_req,
	input  wire logic        dbg_ack_pin,
	input  wire logic        async_abort_pin,
	output logic             in_halt,
	output logic             abort_exc,
	output logic             irq
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_DRAIN = 3'b010,
		ST_HALT  = 3'b100
	} dcc_state_e;

	typedef struct packed {
		dcc_state_e                state;
		logic [1:0]                drain_cnt;
		logic [1:0]                mode;
		logic [31:0]               rx_data;
		logic [31:0]               tx_data;
		logic                      rx_full;
		logic                      tx_full;
		logic                      rx_latched;
		logic                      tx_latched;
		logic                      abort_sticky;
		logic                      abort_discard;
		logic                      abort_pending;
		logic [dcc_pkg::IRQ_W-1:0] irq_stat;
		logic [dcc_pkg::IRQ_W-1:0] irq_en;
		logic                      irq;
		logic                      abort_prev;
	} dcc_top_s;

	dcc_top_s          st_ff;
	dcc_top_s          nxt_st;
	dcc_pkg::dcc_req_s req;
	dcc_pkg::dcc_rsp_s rsp;
	logic              halt_s;
	logic              ack_s;
	logic              abort_s;
	logic              abort_edge;
	logic              nonblock;
	logic [31:0]       status_word;
	logic [dcc_pkg::IRQ_W-1:0] ev;

	function automatic logic hit(input dcc_pkg::dcc_req_s r,
		input logic [7:0] a);
		hit = r.addr == a;
	endfunction

	// ****************************************************************
	// bus slave and pin synchronisers
	// ****************************************************************
	dcc_axil u_axil (
		.clk       (clk),
		.nrst      (nrst),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.req       (req),
		.rsp       (rsp)
	);

	dcc_sync u_sync_halt (
		.clk  (clk),
		.nrst (nrst),
		.d    (halt_req),
		.q    (halt_s)
	);

	dcc_sync u_sync_ack (
		.clk  (clk),
		.nrst (nrst),
		.d    (dbg_ack_pin),
		.q    (ack_s)
	);

	dcc_sync u_sync_abort (
		.clk  (clk),
		.nrst (nrst),
		.d    (async_abort_pin),
		.q    (abort_s)
	);

	assign nonblock   = st_ff.mode == dcc_pkg::MODE_NONBLOCK;
	assign abort_edge = abort_s && !st_ff.abort_prev;

	// ****************************************************************
	// register read decode
	// ****************************************************************
	always_comb begin
		status_word = '0;
		status_word[dcc_pkg::POS_RX_FULL]      = st_ff.rx_full;
		status_word[dcc_pkg::POS_TX_FULL]      = st_ff.tx_full;
		status_word[dcc_pkg::POS_RX_LATCHED]   = st_ff.rx_latched;
		status_word[dcc_pkg::POS_TX_LATCHED]   = st_ff.tx_latched;
		status_word[dcc_pkg::POS_ABORT_STICKY] = st_ff.abort_sticky;
		status_word[dcc_pkg::POS_ABORT_DISC]   = st_ff.abort_discard;
		status_word[dcc_pkg::POS_HALTED]       = st_ff.state == ST_HALT;
		status_word[dcc_pkg::POS_DBG_ACK]      = ack_s;
		status_word[dcc_pkg::POS_MODE_LO +: 2] = st_ff.mode;
	end

	always_comb begin
		rsp.hit   = 1'b1;
		rsp.rdata = '0;
		case (req.addr)
			dcc_pkg::ADDR_STATUS_EXT: rsp.rdata = status_word;
			dcc_pkg::ADDR_RX_EXT:     rsp.rdata = '0;
			dcc_pkg::ADDR_TX_EXT:     rsp.rdata = st_ff.tx_data;
			dcc_pkg::ADDR_IRQ_STAT:   rsp.rdata = {28'h0, st_ff.irq_stat};
			dcc_pkg::ADDR_IRQ_CLR:    rsp.rdata = '0;
			dcc_pkg::ADDR_IRQ_EN:     rsp.rdata = {28'h0, st_ff.irq_en};
			dcc_pkg::ADDR_CORE_RX:    rsp.rdata = st_ff.rx_data;
			dcc_pkg::ADDR_CORE_TX:    rsp.rdata = st_ff.tx_data;
			default:                  rsp.hit   = 1'b0;
		endcase
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		ev     = '0;
		nxt_st.abort_prev = abort_s;

		// core side of the channel
		// core read drains rx
		if (core_rx_rd && st_ff.rx_full) begin
			nxt_st.rx_full = 1'b0;
			ev[dcc_pkg::IRQ_RX_READY] = 1'b1;
		end
		// tx full until debugger takes it
		if (core_tx_wr && !st_ff.tx_full) begin
			nxt_st.tx_data = core_tx_data;
			nxt_st.tx_full = 1'b1;
		end

		// debugger writes
		if (req.wr) begin
			if (hit(req, dcc_pkg::ADDR_STATUS_EXT)) begin
				nxt_st.mode = req.wdata[dcc_pkg::POS_MODE_LO +: 2];
				nxt_st.abort_sticky = req.wdata[dcc_pkg::POS_ABORT_STICKY];
			end
			if (hit(req, dcc_pkg::ADDR_RX_EXT)) begin
				if (nonblock && st_ff.rx_latched) begin
					ev[dcc_pkg::IRQ_RX_DROP] = 1'b1;
				end else begin
					nxt_st.rx_data = req.wdata;
					nxt_st.rx_full = 1'b1;
				end
				nxt_st.rx_latched = 1'b1;
			end
			if (hit(req, dcc_pkg::ADDR_IRQ_EN)) begin
				nxt_st.irq_en = req.wdata[dcc_pkg::IRQ_W-1:0];
			end
			if (hit(req, dcc_pkg::ADDR_IRQ_CLR)) begin
				nxt_st.irq_stat = st_ff.irq_stat &
					~req.wdata[dcc_pkg::IRQ_W-1:0];
			end
		end

		// debugger reads
		if (req.rd) begin
			if (hit(req, dcc_pkg::ADDR_STATUS_EXT)) begin
				nxt_st.rx_latched = st_ff.rx_full;
				nxt_st.tx_latched = st_ff.tx_full;
			end
			if (hit(req, dcc_pkg::ADDR_TX_EXT)) begin
				// a core write landing in this cycle is kept
				if (st_ff.tx_full && !(nonblock && !st_ff.tx_latched)) begin
					nxt_st.tx_full = 1'b0;
					ev[dcc_pkg::IRQ_TX_READY] = 1'b1;
				end
				nxt_st.tx_latched = 1'b0;
			end
		end

		// abort handling and halt sequencing
		if (abort_edge) begin
			if (st_ff.abort_discard && st_ff.state == ST_HALT) begin
				nxt_st.abort_sticky = 1'b1;
				ev[dcc_pkg::IRQ_ABORT] = 1'b1;
			end else begin
				nxt_st.abort_pending = 1'b1;
			end
		end
		if (st_ff.abort_pending) begin
			nxt_st.abort_pending = 1'b0;
		end

		case (st_ff.state)
			ST_RUN: begin
				nxt_st.abort_discard = 1'b0;
				if (halt_s) begin
					nxt_st.state     = ST_DRAIN;
					nxt_st.drain_cnt = 2'(dcc_pkg::HALT_DRAIN_CYCLES);
				end
			end
			ST_DRAIN: begin
				if (!halt_s) begin
					nxt_st.state = ST_RUN;
				end else if (st_ff.drain_cnt != 2'h0) begin
					nxt_st.drain_cnt = st_ff.drain_cnt - 2'h1;
				end else if (!abort_s && !st_ff.abort_pending) begin
					nxt_st.state = ST_HALT;
					nxt_st.abort_discard = 1'b1;
				end
			end
			ST_HALT: begin
				if (!halt_s) begin
					nxt_st.state         = ST_RUN;
					nxt_st.abort_discard = 1'b0;
				end
			end
			default: begin
				nxt_st.state = ST_RUN;
			end
		endcase

		// sticky events; set wins over clear
		nxt_st.irq_stat = nxt_st.irq_stat | ev;
		nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_en);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff          <= '0;
			st_ff.state    <= ST_RUN;
			st_ff.mode     <= dcc_pkg::MODE_RESET;
			st_ff.rx_data  <= dcc_pkg::DATA_RESET;
			st_ff.tx_data  <= dcc_pkg::DATA_RESET;
			st_ff.irq_stat <= dcc_pkg::IRQ_RESET;
			st_ff.irq_en   <= dcc_pkg::IRQ_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign core_rx_data = st_ff.rx_data;
	assign core_rx_full = st_ff.rx_full;
	assign core_tx_full = st_ff.tx_full;
	assign in_halt      = st_ff.state == ST_HALT;
	assign abort_exc    = st_ff.abort_pending;
	assign irq          = st_ff.irq;
endmodule
`default_nettype wire

// >>> testbench/dcc_top_props.sv
/*
 * port checker for dcc_top, attached by bind.
 * assumes one clock and an async active-low nrst.
 */
`timescale 1ns/1ps
`default_nettype none
module dcc_top_props (
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic s_bvalid,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic core_rx_rd,
	input wire logic core_rx_full,
	input wire logic core_tx_wr,
	input wire logic core_tx_full,
	input wire logic halt_req,
	input wire logic async_abort_pin,
	input wire logic in_halt,
	input wire logic abort_exc
);
	// ********************
	// properties
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_abort_run;
		$rose(async_abort_pin) && !in_halt && !halt_req;
	endsequence
	sequence s_halt_hold;
		(halt_req && !async_abort_pin) [*8];
	endsequence
	property p_wr_resp;
		s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:3] s_bvalid;
	endproperty
	property p_rd_resp; s_arvalid && s_arready |-> ##[1:2] s_rvalid; endproperty
	property p_refuse;
		s_rvalid && !s_rready |=> s_rvalid && !s_arready;
	endproperty
	property p_rx_clear; core_rx_rd && core_rx_full |=> !core_rx_full; endproperty
	property p_tx_full; core_tx_wr && !core_tx_full |=> core_tx_full; endproperty
	property p_no_exc; in_halt && $past(in_halt) |-> !abort_exc; endproperty
	property p_abort_run; s_abort_run |-> ##[1:8] abort_exc; endproperty
	property p_halt_in; s_halt_hold |-> ##3 in_halt; endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write response late");
	a_rd_resp: assert property (p_rd_resp)
		else $error("read response late");
	a_refuse: assert property (p_refuse)
		else $error("read taken while busy");
	a_rx_clear: assert property (p_rx_clear)
		else $error("rx full not cleared");
	a_tx_full: assert property (p_tx_full)
		else $error("tx full not set");
	a_no_exc: assert property (p_no_exc)
		else $error("abort passed in halt");
	a_abort_run: assert property (p_abort_run)
		else $error("abort dropped outside halt");
	a_halt_in: assert property (p_halt_in)
		else $error("halt not entered");
endmodule
bind dcc_top dcc_top_props u_props (
	.clk(clk), .nrst(nrst), .s_awvalid(s_awvalid), .s_awready(s_awready),
	.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid),
	.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
	.s_rready(s_rready),
	.core_rx_rd(core_rx_rd), .core_rx_full(core_rx_full),
	.core_tx_wr(core_tx_wr), .core_tx_full(core_tx_full),
	.halt_req(halt_req), .async_abort_pin(async_abort_pin),
	.in_halt(in_halt), .abort_exc(abort_exc)
);
`default_nettype wire

// >>> testbench/dcc_dbg_model.sv
/*
 * external debugger model: axi4-lite master tasks.
 * assumes the slave ports of dcc_top on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dcc_dbg_model (
	input  wire logic        clk,
	output logic [7:0]       s_awaddr,
	output logic             s_awvalid,
	input  wire logic        s_awready,
	output logic [31:0]      s_wdata,
	output logic [3:0]       s_wstrb,
	output logic             s_wvalid,
	input  wire logic        s_wready,
	input  wire logic [1:0]  s_bresp,
	input  wire logic        s_bvalid,
	output logic             s_bready,
	output logic [7:0]       s_araddr,
	output logic             s_arvalid,
	input  wire logic        s_arready,
	input  wire logic [31:0] s_rdata,
	input  wire logic [1:0]  s_rresp,
	input  wire logic        s_rvalid,
	output logic             s_rready
);
	// ********************
	// bus tasks
	// ********************
	initial begin
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
		{s_awaddr, s_araddr} = 16'h0;
		s_wdata = 32'h0;
		s_wstrb = 4'hF;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ha, hw, hb;
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= d;
		{s_awvalid, s_wvalid, s_bready} <= 3'h7;
		hb = 1'b0;
		while (!hb) begin
			@(negedge clk);
			ha = s_awvalid && s_awready;
			hw = s_wvalid && s_wready;
			hb = s_bvalid && s_bready;
			r = s_bresp;
			@(posedge clk);
			if (ha) s_awvalid <= 1'b0;
			if (hw) s_wvalid <= 1'b0;
			if (hw) s_wdata <= ~d;
			if (hb) s_bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ha, hr;
		@(posedge clk);
		s_araddr <= a;
		{s_arvalid, s_rready} <= 2'h3;
		hr = 1'b0;
		while (!hr) begin
			@(negedge clk);
			ha = s_arvalid && s_arready;
			hr = s_rvalid && s_rready;
			d = s_rdata;
			r = s_rresp;
			@(posedge clk);
			if (ha) s_arvalid <= 1'b0;
			if (hr) s_rready <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb_debug_comms_channel_flags.sv
/*
 * self-checking bench for the debug comms channel.
 * assumes dcc_pkg, dcc_top and the debugger model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_debug_comms_channel_flags;
	// ********************
	// signals and cases
	// ********************
	localparam logic [7:0] ST = dcc_pkg::ADDR_STATUS_EXT;
	localparam logic [7:0] RX = dcc_pkg::ADDR_RX_EXT;
	localparam logic [7:0] TX = dcc_pkg::ADDR_TX_EXT;
	localparam logic [7:0] IS = dcc_pkg::ADDR_IRQ_STAT;
	localparam logic [7:0] CR = dcc_pkg::ADDR_CORE_RX;
	localparam logic [31:0] F = 32'hFFFF_FFFF;
	localparam logic [31:0] Z = 32'h0;
	typedef enum logic [2:0] {W, R, C, T, I} dcc_op_e;
	typedef struct packed {
		dcc_op_e     k;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] m;
	} dcc_row_s;
	logic        clk, nrst, core_rx_rd, core_tx_wr, halt_req, dbg_ack_pin;
	logic        async_abort_pin, core_rx_full, core_tx_full, in_halt;
	logic        abort_exc, irq, s_awvalid, s_awready, s_wvalid, s_wready;
	logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
	logic        seen;
	logic [7:0]  s_awaddr, s_araddr;
	logic [1:0]  s_bresp, s_rresp, rr;
	logic [3:0]  s_wstrb;
	logic [31:0] s_wdata, s_rdata, core_tx_data, core_rx_data, rd;
	int          error_cnt, n_tests;
	dcc_row_s    rows [29] = '{
		'{R, ST, Z, 32'h3FF},
		'{W, RX, 32'hA5, Z},
		'{R, CR, 32'hA5, F},
		'{W, RX, 32'h5A, Z},
		'{R, IS, 32'h1, 32'h1},
		'{I, Z[7:0], Z, Z},
		'{W, dcc_pkg::ADDR_IRQ_EN, 32'h1, Z},
		'{I, Z[7:0], 32'h1, Z},
		'{W, dcc_pkg::ADDR_IRQ_CLR, 32'h1, Z},
		'{I, Z[7:0], Z, Z},
		'{R, ST, 32'h5, 32'h7},
		'{C, Z[7:0], Z, Z},
		'{W, RX, 32'h11, Z},
		'{R, CR, 32'hA5, F},
		'{R, ST, Z, 32'h3},
		'{W, RX, 32'h22, Z},
		'{R, CR, 32'h22, F},
		'{T, Z[7:0], 32'h33, Z},
		'{R, ST, 32'h2, 32'h2},
		'{R, TX, 32'h33, F},
		'{T, Z[7:0], 32'h44, Z},
		'{R, TX, 32'h44, F},
		'{R, ST, 32'h2, 32'h2},
		'{R, TX, 32'h44, F},
		'{R, ST, Z, 32'h2},
		'{W, ST, 32'h100, Z},
		'{W, RX, 32'h66, Z},
		'{W, RX, 32'h77, Z},
		'{R, CR, 32'h77, F}
	};
	dcc_top dut (.*);
	dcc_dbg_model dbg (.*);
	// ********************
	// tasks
	// ********************
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t: word %h not %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t: bit %b not %b", $time, g, e);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
		dbg.rd(a, rd, rr);
		chk_word(rd & m, e);
		chk_word({30'h0, rr}, {30'h0, dcc_pkg::AXI_OKAY});
	endtask
	task automatic pulse(output logic s);
		s = 1'b0;
		@(posedge clk);
		async_abort_pin <= 1'b1;
		repeat (8) begin
			@(negedge clk);
			s = s | (abort_exc === 1'b1);
		end
		@(posedge clk);
		async_abort_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic wait_halt(input logic e);
		for (int n = 0; n < 50 && in_halt !== e; n++)
			@(negedge clk);
		chk_bit(in_halt, e);
	endtask
	task automatic run(input dcc_row_s x);
		case (x.k)
			W: begin
				dbg.wr(x.a, x.d, rr);
				chk_word({30'h0, rr}, {30'h0, dcc_pkg::AXI_OKAY});
			end
			R: rdc(x.a, x.d, x.m);
			I: begin
				repeat (2) @(posedge clk);
				@(negedge clk);
				chk_bit(irq, x.d[0]);
			end
			default: begin
				@(posedge clk);
				core_rx_rd <= (x.k == C);
				core_tx_wr <= (x.k == T);
				core_tx_data <= x.d;
				@(posedge clk);
				{core_rx_rd, core_tx_wr} <= 2'h0;
			end
		endcase
	endtask
	// ********************
	// sequence
	// ********************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{nrst, core_rx_rd, core_tx_wr, halt_req} = 4'h0;
		{dbg_ack_pin, async_abort_pin} = 2'h0;
		core_tx_data = 32'h0;
		error_cnt = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk_bit(core_rx_full, 1'b0);
		rdc(ST, Z, 32'h3FF);
		$display("reset test done");
		dbg.wr(RX, 32'h99, rr);
		@(negedge clk);
		chk_word(core_rx_data, 32'h99);
		chk_bit(core_rx_full, 1'b1);
		@(posedge clk);
		core_tx_wr <= 1'b1;
		core_tx_data <= 32'h55;
		@(posedge clk);
		core_tx_wr <= 1'b0;
		@(negedge clk);
		chk_bit(core_tx_full, 1'b1);
		@(posedge clk);
		$display("core side test done");
		dbg_ack_pin <= 1'b1;
		pulse(seen);
		chk_bit(seen, 1'b1);
		rdc(ST, 32'h80, 32'hB0);
		halt_req <= 1'b1;
		wait_halt(1'b1);
		rdc(ST, 32'hE0, 32'hF0);
		pulse(seen);
		chk_bit(seen, 1'b0);
		rdc(ST, 32'h10, 32'h10);
		rdc(IS, 32'h2, 32'h2);
		dbg.wr(ST, Z, rr);
		rdc(ST, Z, 32'h10);
		halt_req <= 1'b0;
		wait_halt(1'b0);
		rdc(ST, Z, 32'h60);
		$display("abort test done");
		dbg.rd(8'hFC, rd, rr);
		chk_word({30'h0, rr}, {30'h0, dcc_pkg::AXI_SLVERR});
		$display("unmapped test done");
		end_of_test;
	end
	initial begin
		#300000;
		error_cnt++;
		$display("ERROR %0t: timeout", $time);
		end_of_test;
	end
endmodule
`default_nettype wire
